// ===== rtl/dic_cfg.svh
// Constants of the signal processor interrupt controller: field positions,
// reset values and counts. Included by bare name, definitions only.
`ifndef DIC_CFG_SVH
`define DIC_CFG_SVH

// ****************************************************************
// Interrupt control register fields
// ****************************************************************
`define DIC_B_HOST_PEND 15
`define DIC_B_ADC_PEND 14
`define DIC_B_DAC_PEND 13
`define DIC_B_MASK_HI 12
`define DIC_B_MASK_MID 11
`define DIC_B_MASK_LO 10
`define DIC_B_HOST_REQ 9
`define DIC_B_GLOBAL_EN 8
`define DIC_B_ROUTE_HI 7
`define DIC_B_ROUTE_LO 5
`define DIC_B_CLR_HOST 4
`define DIC_B_CLR_ADC 3
`define DIC_B_CLR_DAC 2

// ****************************************************************
// Analog control register fields
// ****************************************************************
`define DIC_B_DAC_SRC 15
`define DIC_B_ACR_ONE 9

// ****************************************************************
// Host side bit positions
// ****************************************************************
`define DIC_B_HOST_SET 0
`define DIC_B_HOST_CLR 0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define DIC_RST_MASK 3'h0
`define DIC_RST_ROUTE 3'h0
`define DIC_RST_GEN 1'h0
`define DIC_RST_DAC_SRC 1'h0
`define DIC_AUTO_CLR_INSTR 2'h3

`endif

// ===== rtl/dic_pkg.sv
// Types of the signal processor interrupt controller.
// Assumes dic_cfg.svh supplies the numeric constants.
package dic_pkg;

  // One bit per priority level
  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
  } dic_lvl_t;

  // One bit per source
  typedef struct packed {
    logic host;
    logic adc;
    logic dac;
  } dic_src_t;

  typedef enum logic {
    DIC_IDLE,
    DIC_SERVING
  } dic_state_t;

endpackage

// ===== rtl/dic_sync.sv
// Two flip-flop synchroniser for one level.
// Assumes a single clock, synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none

module dic_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic d,
  output logic q
);

  logic meta_r;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      meta_r <= 1'h0;
      q <= 1'h0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/dic_top.sv
// Interrupt controller of the signal processor core: pending flags, routing,
// masks, global enable, non-nested service and the request to the host.
// Assumes register strobes are one-cycle pulses on mclk; ext_irq_pin is async.
`timescale 1ns/1ps
`default_nettype none
`include "dic_cfg.svh"

module dic_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic icr_wr,
  input wire logic icr_rd,
  input wire logic [15:0] icr_wdata,
  output logic [15:0] icr_rdata,
  input wire logic acr_wr,
  input wire logic acr_rd,
  input wire logic [15:0] acr_wdata,
  output logic [15:0] acr_rdata,
  input wire logic host_ctl_wr,
  input wire logic link_ctrl_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_instr_done,
  output logic host_pend_out,
  output logic host_request_out,
  input wire logic adc_done,
  input wire logic dac_timer_tick,
  input wire logic ext_irq_pin,
  input wire logic core_ack,
  input wire logic core_reti,
  output dic_pkg::dic_lvl_t irq_level,
  output logic in_service
);

  // ****************************************************************
  // Routing
  // ****************************************************************
  function automatic dic_pkg::dic_lvl_t dic_route(input logic [2:0] code,
                                                  input dic_pkg::dic_src_t p);
    dic_pkg::dic_lvl_t l;
    l = '0;
    case (code)
      3'h0: l = '{hi: p.host, mid: p.adc, lo: p.dac};
      3'h1: l = '{hi: p.adc, mid: p.host, lo: p.dac};
      3'h2: l = '{hi: p.host, mid: p.dac, lo: p.adc};
      3'h3: l = '{hi: p.dac, mid: p.host, lo: p.adc};
      3'h4: l = '{hi: p.adc, mid: p.dac, lo: p.host};
      3'h5: l = '{hi: p.dac, mid: p.adc, lo: p.host};
      default: l = '0;
    endcase
    return l;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  dic_pkg::dic_src_t pend_r;
  dic_pkg::dic_lvl_t mask_r;
  logic gen_r;
  logic [2:0] route_r;
  logic dac_src_r;
  logic pin_sync;
  logic pin_prev_r;
  logic dac_evt;
  logic [1:0] clr_cnt_r;
  logic clr_run_r;
  dic_pkg::dic_state_t state_r;
  dic_pkg::dic_lvl_t routed;
  dic_pkg::dic_lvl_t elig;
  dic_pkg::dic_lvl_t irq_nxt;

  dic_sync dic_sync_inst (
    .mclk(mclk),
    .resetn(resetn),
    .d(ext_irq_pin),
    .q(pin_sync)
  );

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      pin_prev_r <= 1'h0;
    else
      pin_prev_r <= pin_sync;
  end

  // Output flag source: rising pin edge or sample timer
  assign dac_evt = dac_src_r ? (pin_sync & ~pin_prev_r) : dac_timer_tick;

  // ****************************************************************
  // Pending flags: set wins over a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      pend_r <= '0;
    else
    begin
      if (host_ctl_wr && host_wdata[`DIC_B_HOST_SET])
        pend_r.host <= 1'h1;
      else if (icr_wr && icr_wdata[`DIC_B_CLR_HOST])
        pend_r.host <= 1'h0;
      if (adc_done)
        pend_r.adc <= 1'h1;
      else if (icr_wr && icr_wdata[`DIC_B_CLR_ADC])
        pend_r.adc <= 1'h0;
      if (dac_evt)
        pend_r.dac <= 1'h1;
      else if (icr_wr && icr_wdata[`DIC_B_CLR_DAC])
        pend_r.dac <= 1'h0;
    end
  end

  // ****************************************************************
  // Control fields
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      mask_r <= `DIC_RST_MASK;
      gen_r <= `DIC_RST_GEN;
      route_r <= `DIC_RST_ROUTE;
    end
    else if (icr_wr)
    begin
      mask_r <= icr_wdata[`DIC_B_MASK_HI:`DIC_B_MASK_LO];
      gen_r <= icr_wdata[`DIC_B_GLOBAL_EN];
      route_r <= icr_wdata[`DIC_B_ROUTE_HI:`DIC_B_ROUTE_LO];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      dac_src_r <= `DIC_RST_DAC_SRC;
    else if (acr_wr)
      dac_src_r <= acr_wdata[`DIC_B_DAC_SRC];
  end

  // ****************************************************************
  // Request to the host
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      clr_run_r <= 1'h0;
      clr_cnt_r <= 2'h0;
    end
    else if (link_ctrl_wr && host_wdata[`DIC_B_HOST_CLR])
    begin
      clr_run_r <= 1'h1;
      clr_cnt_r <= 2'h0;
    end
    else if (clr_run_r && host_instr_done)
    begin
      clr_cnt_r <= clr_cnt_r + 2'h1;
      if (clr_cnt_r + 2'h1 == `DIC_AUTO_CLR_INSTR)
        clr_run_r <= 1'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      host_request_out <= 1'h0;
    else if (icr_wr)
      host_request_out <= icr_wdata[`DIC_B_HOST_REQ];
    else if (clr_run_r && host_instr_done && clr_cnt_r + 2'h1 == `DIC_AUTO_CLR_INSTR)
      host_request_out <= 1'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      host_pend_out <= 1'h0;
    else
      host_pend_out <= pend_r.host;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      icr_rdata <= 16'h0000;
    else if (icr_rd)
      icr_rdata <= {pend_r, mask_r, 1'h0, gen_r, route_r, 5'h00};
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      acr_rdata <= 16'h0000;
    else if (acr_rd)
      acr_rdata <= {dac_src_r, 5'h00, 1'h1, 9'h000};
  end

  // ****************************************************************
  // Eligibility and service
  // ****************************************************************
  always_comb
  begin
    routed = dic_route(route_r, pend_r);
    elig = routed & mask_r & {3{gen_r}};
    irq_nxt = '0;
    if (state_r == dic_pkg::DIC_IDLE && !core_ack)
    begin
      if (elig.hi)
        irq_nxt.hi = 1'h1;
      else if (elig.mid)
        irq_nxt.mid = 1'h1;
      else if (elig.lo)
        irq_nxt.lo = 1'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq_level <= '0;
    else
      irq_level <= irq_nxt;
  end

  // Service flag is kept in its own flop so the output comes from a register
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_r <= dic_pkg::DIC_IDLE;
      in_service <= 1'h0;
    end
    else
      case (state_r)
        dic_pkg::DIC_IDLE:
          if (core_ack && irq_level != '0)
          begin
            state_r <= dic_pkg::DIC_SERVING;
            in_service <= 1'h1;
          end
        dic_pkg::DIC_SERVING:
          if (core_reti)
          begin
            state_r <= dic_pkg::DIC_IDLE;
            in_service <= 1'h0;
          end
        default:
        begin
          state_r <= dic_pkg::DIC_IDLE;
          in_service <= 1'h0;
        end
      endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_no_nesting: assert property (@(posedge mclk) disable iff (!resetn)
    in_service |=> irq_level == '0)
    else $error("level presented during service");

  a_prio_order: assert property (@(posedge mclk) disable iff (!resetn)
    $countones(irq_level) <= 1)
    else $error("more than one level presented");

  a_hi_first: assert property (@(posedge mclk) disable iff (!resetn)
    (elig.hi && !in_service && !core_ack) |=> irq_level.hi)
    else $error("high level not presented first");

  a_host_set: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(pend_r.host) |-> $past(host_ctl_wr && host_wdata[`DIC_B_HOST_SET]))
    else $error("host flag set without host write");

  a_clr_flags: assert property (@(posedge mclk) disable iff (!resetn)
    (icr_wr && icr_wdata[`DIC_B_CLR_ADC] && !adc_done) |=> !pend_r.adc)
    else $error("converter flag not cleared");

  a_gen_gate: assert property (@(posedge mclk) disable iff (!resetn)
    !gen_r |=> irq_level == '0)
    else $error("level presented while disabled");

  a_bit9_read: assert property (@(posedge mclk) disable iff (!resetn)
    icr_rd |=> icr_rdata[`DIC_B_HOST_REQ] == 1'h0 && icr_rdata[1:0] == 2'h0)
    else $error("unstored bits read nonzero");

  a_req_write: assert property (@(posedge mclk) disable iff (!resetn)
    icr_wr |=> host_request_out == $past(icr_wdata[`DIC_B_HOST_REQ]))
    else $error("host request not following write");

  a_mask_gate: assert property (@(posedge mclk) disable iff (!resetn)
    !mask_r.lo |=> !irq_level.lo)
    else $error("masked level presented");

  a_reset_gen: assert property (@(posedge mclk)
    !resetn |=> !gen_r)
    else $error("global enable survives reset");

endmodule

`default_nettype wire

// ===== sim/dic_host_model.sv
// Host processor and converter timers facing the interrupt controller.
// Assumes the bench calls its tasks; every change lands at a falling edge.
`timescale 1ns/1ps
`default_nettype none

module dic_host_model (
  input wire logic mclk,
  output logic host_ctl_wr,
  output logic link_ctrl_wr,
  output logic [7:0] host_wdata,
  output logic host_instr_done,
  output logic adc_done,
  output logic dac_timer_tick,
  output logic ext_irq_pin
);
  initial
  begin
    {host_ctl_wr, link_ctrl_wr, host_instr_done, adc_done} = 4'h0;
    {dac_timer_tick, ext_irq_pin} = 2'h0;
    host_wdata = 8'h00;
  end

  // ********************
  // Events
  // ********************
  // Host flag write, conversion done and timer event, in one cycle
  task automatic ev(input logic h, input logic a, input logic d);
    @(negedge mclk);
    host_wdata = 8'h01;
    host_ctl_wr = h;
    adc_done = a;
    dac_timer_tick = d;
    @(negedge mclk);
    {host_ctl_wr, adc_done, dac_timer_tick} = 3'h0;
    host_wdata = 8'hfe;
  endtask

  // End of the host routine: start the three-instruction count that releases the request
  task automatic link_clear;
    @(negedge mclk);
    host_wdata = 8'h01;
    link_ctrl_wr = 1'b1;
    @(negedge mclk);
    link_ctrl_wr = 1'b0;
    host_wdata = 8'hfe;
  endtask

  task automatic instr(input int n);
    repeat (n)
    begin
      @(negedge mclk);
      host_instr_done = 1'b1;
      @(negedge mclk);
      host_instr_done = 1'b0;
    end
  endtask

  task automatic pin_rise;
    @(negedge mclk);
    ext_irq_pin = 1'b1;
    repeat (4) @(negedge mclk);
    ext_irq_pin = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
endmodule

`default_nettype wire

// ===== sim/tb_dsp_irq_controller.sv
// Self-checking bench of the signal processor interrupt controller.
// Assumes dic_host_model stands in for the host processor and timers.
`timescale 1ns/1ps
`default_nettype none

module tb_dsp_irq_controller;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic icr_wr = 1'b0, icr_rd = 1'b0, acr_wr = 1'b0, acr_rd = 1'b0;
  logic [15:0] icr_wdata = 16'h0000, acr_wdata = 16'h0000;
  logic core_ack = 1'b0, core_reti = 1'b0;
  logic host_ctl_wr, link_ctrl_wr, host_instr_done, adc_done, dac_timer_tick, ext_irq_pin;
  logic [7:0] host_wdata;
  logic [15:0] icr_rdata, acr_rdata;
  logic host_pend_out, host_request_out, in_service;
  dic_pkg::dic_lvl_t irq_level;
  int n_mismatch = 0;
  int tests_run = 0;

  always #5 mclk = ~mclk;

  dic_top dic_top_inst (.mclk(mclk), .resetn(resetn), .icr_wr(icr_wr), .icr_rd(icr_rd),
    .icr_wdata(icr_wdata), .icr_rdata(icr_rdata), .acr_wr(acr_wr), .acr_rd(acr_rd),
    .acr_wdata(acr_wdata), .acr_rdata(acr_rdata), .host_ctl_wr(host_ctl_wr),
    .link_ctrl_wr(link_ctrl_wr), .host_wdata(host_wdata), .host_instr_done(host_instr_done),
    .host_pend_out(host_pend_out), .host_request_out(host_request_out), .adc_done(adc_done),
    .dac_timer_tick(dac_timer_tick), .ext_irq_pin(ext_irq_pin), .core_ack(core_ack),
    .core_reti(core_reti), .irq_level(irq_level), .in_service(in_service));

  dic_host_model dic_host_model_inst (.mclk(mclk), .host_ctl_wr(host_ctl_wr),
    .link_ctrl_wr(link_ctrl_wr), .host_wdata(host_wdata), .host_instr_done(host_instr_done),
    .adc_done(adc_done), .dac_timer_tick(dac_timer_tick), .ext_irq_pin(ext_irq_pin));

  // ********************
  // Helpers
  // ********************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Control word: masks, host request, enable, route, clear bits
  function automatic logic [15:0] w(input logic [2:0] m, input logic g, input logic [2:0] r,
    input logic [2:0] c, input logic h);
    return {3'h0, m, h, g, r, c, 2'h0};
  endfunction

  task automatic reg_w(input logic analog_control, input logic [15:0] d);
    @(negedge mclk);
    if (analog_control) {acr_wr, acr_wdata} = {1'b1, d};
    else {icr_wr, icr_wdata} = {1'b1, d};
    @(negedge mclk);
    {acr_wr, icr_wr} = 2'h0;
  endtask

  task automatic reg_r(input logic analog_control);
    @(negedge mclk);
    if (analog_control) acr_rd = 1'b1;
    else icr_rd = 1'b1;
    @(negedge mclk);
    {acr_rd, icr_rd} = 2'h0;
  endtask

  task automatic core(input logic ack);
    @(negedge mclk);
    if (ack) core_ack = 1'b1;
    else core_reti = 1'b1;
    @(negedge mclk);
    {core_ack, core_reti} = 2'h0;
  endtask

  task automatic lvl(input string what, input logic [2:0] exp);
    cyc(3);
    chk(what, {13'h0, exp}, {13'h0, irq_level});
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    reg_r(0);
    chk("icr reset", 16'h0000, icr_rdata);
    reg_r(1);
    chk("acr reset", 16'h0200, acr_rdata);
    reg_w(0, 16'he003);
    reg_r(0);
    chk("icr ignored bits", 16'h0000, icr_rdata);
    $display("test reset done");
  endtask

  task automatic t_service;
    reg_w(0, w(3'h7, 1'b1, 3'h0, 3'h0, 1'b0));
    dic_host_model_inst.ev(1'b0, 1'b1, 1'b0);
    lvl("adc level", 3'b010);
    core(1'b1);
    chkb("in service", 1'b1, in_service);
    dic_host_model_inst.ev(1'b1, 1'b0, 1'b0);
    lvl("level while serving", 3'b000);
    reg_w(0, w(3'h7, 1'b1, 3'h0, 3'h2, 1'b0));
    core(1'b0);
    chkb("out of service", 1'b0, in_service);
    lvl("host level", 3'b100);
    chkb("host pend out", 1'b1, host_pend_out);
    reg_r(0);
    chk("icr after clear", 16'h9d00, icr_rdata);
    reg_w(0, w(3'h7, 1'b1, 3'h0, 3'h4, 1'b0));
    lvl("host cleared", 3'b000);
    chkb("host pend out clear", 1'b0, host_pend_out);
    $display("test service done");
  endtask

  task automatic t_prio;
    reg_w(0, w(3'h7, 1'b1, 3'h1, 3'h0, 1'b0));
    dic_host_model_inst.ev(1'b1, 1'b1, 1'b0);
    lvl("same cycle winner", 3'b100);
    core(1'b1);
    reg_w(0, w(3'h7, 1'b1, 3'h1, 3'h2, 1'b0));
    core(1'b0);
    lvl("second in line", 3'b010);
    reg_w(0, w(3'h7, 1'b1, 3'h1, 3'h4, 1'b0));
    lvl("all cleared", 3'b000);
    $display("test priority done");
  endtask

  task automatic t_mask;
    reg_w(0, w(3'h6, 1'b1, 3'h0, 3'h0, 1'b0));
    dic_host_model_inst.ev(1'b0, 1'b0, 1'b1);
    lvl("masked", 3'b000);
    reg_w(0, w(3'h7, 1'b0, 3'h0, 3'h0, 1'b0));
    lvl("global off", 3'b000);
    reg_w(0, w(3'h7, 1'b1, 3'h0, 3'h0, 1'b0));
    lvl("unmasked", 3'b001);
    reg_w(0, w(3'h7, 1'b1, 3'h0, 3'h1, 1'b0));
    $display("test mask done");
  endtask

  task automatic t_route;
    logic [2:0] rt [6];
    rt = '{3'b001, 3'b001, 3'b010, 3'b100, 3'b010, 3'b100};
    for (int i = 0; i < 6; i++)
    begin
      reg_w(0, w(3'h7, 1'b1, i[2:0], 3'h0, 1'b0));
      dic_host_model_inst.ev(1'b0, 1'b0, 1'b1);
      lvl("dac route", rt[i]);
      reg_w(0, w(3'h7, 1'b1, i[2:0], 3'h1, 1'b0));
    end
    $display("test route done");
  endtask

  task automatic t_hreq;
    reg_w(0, w(3'h0, 1'b0, 3'h0, 3'h0, 1'b1));
    cyc(1);
    chkb("host request set", 1'b1, host_request_out);
    reg_r(0);
    chk("request bit reads", 16'h0000, icr_rdata);
    dic_host_model_inst.link_clear();
    dic_host_model_inst.instr(2);
    chkb("request held", 1'b1, host_request_out);
    dic_host_model_inst.instr(1);
    cyc(1);
    chkb("request auto clear", 1'b0, host_request_out);
    $display("test host request done");
  endtask

  task automatic t_pin;
    reg_w(1, 16'h8000);
    reg_r(1);
    chk("acr select", 16'h8200, acr_rdata);
    dic_host_model_inst.ev(1'b0, 1'b0, 1'b1);
    reg_r(0);
    chk("tick ignored", 16'h0000, icr_rdata);
    dic_host_model_inst.pin_rise();
    reg_r(0);
    chk("pin sets flag", 16'h2000, icr_rdata);
    reg_w(0, w(3'h0, 1'b0, 3'h0, 3'h1, 1'b0));
    reg_w(1, 16'h0000);
    dic_host_model_inst.ev(1'b0, 1'b0, 1'b1);
    reg_r(0);
    chk("timer sets flag", 16'h2000, icr_rdata);
    $display("test pin select done");
  endtask

  task automatic final_report;
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    cyc(3);
    resetn = 1'b1;
    t_reset();
    t_service();
    t_prio();
    t_mask();
    t_route();
    t_hreq();
    t_pin();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
endmodule

`default_nettype wire
